// [rtl/pic_host_pkg.sv]
package pic_host_pkg;
  // Clock rate and bus phase times
  localparam int CLK_MHZ = 250;
  localparam int SETUP_NS = 20;
  localparam int STROBE_NS = 100;
  localparam int RECOVER_NS = 40;
  // Least times round up to whole cycles
  localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int RECOVER_CYC = (RECOVER_NS * CLK_MHZ + 999) / 1000;
  // Acknowledge pulses per sequence
  localparam int ACK_PULSES_CALL = 3;
  localparam int ACK_PULSES_POINTER = 2;
  // Address select values
  localparam logic ADDR_LOW = 1'b0;
  localparam logic ADDR_HIGH = 1'b1;
  // Write decode bits when address select is low
  localparam int INIT_ONE_BIT = 4;
  localparam int OP_THREE_BIT = 3;
  // Strap level on the dual-function pin
  localparam logic STRAP_MASTER = 1'b1;
  localparam logic STRAP_SLAVE = 1'b0;
  // Reset values
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [23:0] VECTOR_RESET = 24'h000000;

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_SETUP = 6'h02,
    S_STROBE = 6'h04,
    S_RECOVER = 6'h08,
    S_ACK_LOW = 6'h10,
    S_ACK_GAP = 6'h20
  } host_state_t;
endpackage : pic_host_pkg

// [rtl/phase_timer.sv]
`timescale 1ns/100ps
module phase_timer #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  output logic expired
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;

  always_comb begin
    next_count = count;
    if (load) begin
      next_count = load_value;
    end else if (count != '0) begin
      next_count = count - WIDTH'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign expired = (count == '0);
endmodule : phase_timer

// [rtl/pic_host.sv]
`timescale 1ns/100ps
module pic_host #(
  parameter int TIMER_WIDTH = 8,
  parameter logic STRAP = pic_host_pkg::STRAP_MASTER
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic cmd_addr_sel,
  input wire logic [7:0] cmd_data,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  input wire logic ack_enable,
  input wire logic ack_call_mode,
  input wire logic buffered_mode,
  output logic vec_valid,
  output logic [23:0] vec_data,
  output logic [2:0] vec_cascade,
  input wire logic [7:0] raise_req,
  output logic [7:0] request_inputs,
  output logic chip_select_n,
  output logic write_n,
  output logic read_n,
  output logic address_select,
  output logic [7:0] data_out,
  output logic data_oe_n,
  input wire logic [7:0] data_in,
  input wire logic int_in,
  output logic irq_acknowledge_in_n,
  input wire logic [2:0] cascade_lines,
  output logic slave_prog_out,
  output logic slave_prog_oe_n
);
  localparam int TMAX = 2 ** TIMER_WIDTH;

  if (pic_host_pkg::SETUP_CYC > TMAX || pic_host_pkg::STROBE_CYC > TMAX ||
      pic_host_pkg::RECOVER_CYC > TMAX) begin : g_bad_width
    $error("TIMER_WIDTH too small for phase counts");
  end

  // Pulse counter is two bits and the vector holds three bytes
  if (pic_host_pkg::ACK_PULSES_CALL > 3 || pic_host_pkg::ACK_PULSES_CALL < 1 ||
      pic_host_pkg::ACK_PULSES_POINTER > 3 ||
      pic_host_pkg::ACK_PULSES_POINTER < 1) begin : g_bad_pulses
    $error("acknowledge pulse count out of range");
  end

  pic_host_pkg::host_state_t state;
  pic_host_pkg::host_state_t next_state;
  logic is_write;
  logic next_is_write;
  logic next_address_select;
  logic [7:0] next_data_out;
  logic next_rsp_valid;
  logic [7:0] next_rsp_data;
  logic next_vec_valid;
  logic [23:0] next_vec_data;
  logic [2:0] next_vec_cascade;
  logic [1:0] pulse_idx;
  logic [1:0] next_pulse_idx;
  logic [1:0] pulse_last;
  logic [1:0] next_pulse_last;
  logic [7:0] next_request_inputs;
  logic req_clear;
  logic next_chip_select_n;
  logic next_write_n;
  logic next_read_n;
  logic next_data_oe_n;
  logic next_ack_n;
  logic timer_load;
  logic [TIMER_WIDTH-1:0] timer_value;
  logic timer_expired;
  logic ack_start;

  phase_timer #(
    .WIDTH(TIMER_WIDTH)
  ) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .load(timer_load),
    .load_value(timer_value),
    .expired(timer_expired)
  );

  // Acknowledge on a raised interrupt output
  // interrupt starts acknowledge
  assign ack_start = ack_enable && int_in;
  assign cmd_ready = (state == pic_host_pkg::S_IDLE) && !ack_start;

  always_comb begin
    next_state = state;
    next_is_write = is_write;
    next_address_select = address_select;
    next_data_out = data_out;
    next_rsp_valid = 1'b0;
    next_rsp_data = rsp_data;
    next_vec_valid = 1'b0;
    next_vec_data = vec_data;
    next_vec_cascade = vec_cascade;
    next_pulse_idx = pulse_idx;
    next_pulse_last = pulse_last;
    req_clear = 1'b0;
    timer_load = 1'b0;
    timer_value = '0;
    case (state)
      pic_host_pkg::S_IDLE: begin
        if (ack_start) begin
          next_pulse_idx = 2'h0;
          next_pulse_last = ack_call_mode ?
            2'(pic_host_pkg::ACK_PULSES_CALL - 1) :
            2'(pic_host_pkg::ACK_PULSES_POINTER - 1);
          next_vec_data = pic_host_pkg::VECTOR_RESET;
          next_state = pic_host_pkg::S_ACK_LOW;
          timer_load = 1'b1;
          timer_value = TIMER_WIDTH'(pic_host_pkg::STROBE_CYC - 1);
        end else if (cmd_valid) begin
          next_is_write = cmd_write;
          next_address_select = cmd_addr_sel;
          next_data_out = cmd_data;
          next_state = pic_host_pkg::S_SETUP;
          timer_load = 1'b1;
          timer_value = TIMER_WIDTH'(pic_host_pkg::SETUP_CYC - 1);
        end
      end
      pic_host_pkg::S_SETUP: begin
        if (timer_expired) begin
          next_state = pic_host_pkg::S_STROBE;
          timer_load = 1'b1;
          timer_value = TIMER_WIDTH'(pic_host_pkg::STROBE_CYC - 1);
        end
      end
      pic_host_pkg::S_STROBE: begin
        if (timer_expired) begin
          if (!is_write) begin
            next_rsp_data = data_in;
            next_rsp_valid = 1'b1;
          end
          next_state = pic_host_pkg::S_RECOVER;
          timer_load = 1'b1;
          timer_value = TIMER_WIDTH'(pic_host_pkg::RECOVER_CYC - 1);
        end
      end
      pic_host_pkg::S_RECOVER: begin
        if (timer_expired) begin
          next_state = pic_host_pkg::S_IDLE;
        end
      end
      pic_host_pkg::S_ACK_LOW: begin
        if (timer_expired) begin
          next_vec_data[8 * pulse_idx +: 8] = data_in;
          next_vec_cascade = cascade_lines;
          next_state = pic_host_pkg::S_ACK_GAP;
          timer_load = 1'b1;
          timer_value = TIMER_WIDTH'(pic_host_pkg::RECOVER_CYC - 1);
        end
      end
      pic_host_pkg::S_ACK_GAP: begin
        if (timer_expired) begin
          if (pulse_idx == pulse_last) begin
            next_vec_valid = 1'b1;
            req_clear = 1'b1;
            next_state = pic_host_pkg::S_IDLE;
          end else begin
            next_pulse_idx = pulse_idx + 2'h1;
            next_state = pic_host_pkg::S_ACK_LOW;
            timer_load = 1'b1;
            timer_value = TIMER_WIDTH'(pic_host_pkg::STROBE_CYC - 1);
          end
        end
      end
      default: begin
        next_state = pic_host_pkg::S_IDLE;
      end
    endcase
    next_request_inputs = (request_inputs & ~{8{req_clear}}) | raise_req;
    next_chip_select_n = !(next_state == pic_host_pkg::S_SETUP ||
                           next_state == pic_host_pkg::S_STROBE);
    // end of service goes out as a write
    next_write_n = !(next_state == pic_host_pkg::S_STROBE && next_is_write);
    next_read_n = !(next_state == pic_host_pkg::S_STROBE && !next_is_write);
    // release bus on reads and acknowledge
    next_data_oe_n = !(next_is_write &&
                       (next_state == pic_host_pkg::S_SETUP ||
                        next_state == pic_host_pkg::S_STROBE));
    next_ack_n = !(next_state == pic_host_pkg::S_ACK_LOW);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= pic_host_pkg::S_IDLE;
      is_write <= 1'b0;
      address_select <= pic_host_pkg::ADDR_LOW;
      data_out <= pic_host_pkg::BYTE_RESET;
      rsp_valid <= 1'b0;
      rsp_data <= pic_host_pkg::BYTE_RESET;
      vec_valid <= 1'b0;
      vec_data <= pic_host_pkg::VECTOR_RESET;
      vec_cascade <= 3'h0;
      pulse_idx <= 2'h0;
      pulse_last <= 2'h0;
      request_inputs <= 8'h00;
      chip_select_n <= 1'b1;
      write_n <= 1'b1;
      read_n <= 1'b1;
      data_oe_n <= 1'b1;
      irq_acknowledge_in_n <= 1'b1;
    end else begin
      state <= next_state;
      is_write <= next_is_write;
      address_select <= next_address_select;
      data_out <= next_data_out;
      rsp_valid <= next_rsp_valid;
      rsp_data <= next_rsp_data;
      vec_valid <= next_vec_valid;
      vec_data <= next_vec_data;
      vec_cascade <= next_vec_cascade;
      pulse_idx <= next_pulse_idx;
      pulse_last <= next_pulse_last;
      request_inputs <= next_request_inputs;
      chip_select_n <= next_chip_select_n;
      write_n <= next_write_n;
      read_n <= next_read_n;
      data_oe_n <= next_data_oe_n;
      irq_acknowledge_in_n <= next_ack_n;
    end
  end

  // strap drive only when not buffered
  // buffered mode leaves pin to device
  assign slave_prog_out = STRAP;
  assign slave_prog_oe_n = buffered_mode;
endmodule : pic_host

// [sim/pic_host_checker.sv]
`timescale 1ns/100ps
module pic_host_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic vec_valid,
  input wire logic buffered_mode,
  input wire logic chip_select_n,
  input wire logic write_n,
  input wire logic read_n,
  input wire logic data_oe_n,
  input wire logic irq_acknowledge_in_n,
  input wire logic slave_prog_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic take;
  assign take = cmd_valid && cmd_ready;
  chk_strobe_sel: assert property (!write_n || !read_n |-> !chip_select_n)
    else $error("strobe without select");
  chk_ack_free: assert property (!irq_acknowledge_in_n |->
    chip_select_n && data_oe_n)
    else $error("select during acknowledge");
  chk_bus_float: assert property (!data_oe_n |-> !chip_select_n && read_n)
    else $error("host drives bus out of turn");
  chk_take_sel: assert property (take |-> ##[1:2] $fell(chip_select_n))
    else $error("command not started");
  chk_setup_gap: assert property ($fell(chip_select_n) |->
    ##5 ($fell(write_n) || $fell(read_n)))
    else $error("strobe setup wrong");
  chk_wr_width: assert property ($fell(write_n) |->
    ##25 (write_n && chip_select_n))
    else $error("write strobe width wrong");
  chk_rd_answer: assert property ($fell(read_n) |->
    ##25 (read_n && rsp_valid))
    else $error("read answer wrong");
  chk_ack_pulse: assert property ($fell(irq_acknowledge_in_n) |->
    ##25 irq_acknowledge_in_n)
    else $error("acknowledge width wrong");
  chk_vec_end: assert property (vec_valid |-> $past(irq_acknowledge_in_n, 10)
    && !$past(irq_acknowledge_in_n, 11))
    else $error("vector done misplaced");
  chk_strap_dir: assert property (slave_prog_oe_n == buffered_mode)
    else $error("strap pin direction wrong");
  cover property (rsp_valid);
  cover property (vec_valid);
  cover property (!write_n);
endmodule : pic_host_checker

bind pic_host pic_host_checker chk_i (.*);

// [sim/pic_device_model.sv]
`timescale 1ns/100ps
module pic_device_model (
  input wire logic clk,
  input wire logic chip_select_n,
  input wire logic write_n,
  input wire logic read_n,
  input wire logic address_select,
  input wire logic [7:0] data_out,
  input wire logic irq_acknowledge_in_n,
  input wire logic [7:0] request_inputs,
  output logic [7:0] data_in,
  output logic int_in,
  output logic [2:0] cascade_lines
);
  logic [7:0] mask_set = 8'hff;
  logic [7:0] in_service = 8'h00;
  logic [7:0] vec_hi = 8'h00;
  logic [7:0] junk = 8'h5a;
  logic [7:0] pend;
  logic [4:0] idle = 5'h1f;
  logic [1:0] init_left = 2'h0;
  logic [1:0] acks = 2'h0;
  logic show_service = 1'b0;
  logic ack_q = 1'b1;
  logic wr_q = 1'b1;
  logic [2:0] lvl;
  assign pend = request_inputs & ~mask_set;
  always_comb begin
    lvl = 3'h0;
    for (int i = 7; i >= 0; i--)
      if (pend[i]) lvl = 3'(i);
  end
  assign int_in = (pend != 8'h00) && (in_service == 8'h00);
  // master drives level for slave match
  assign cascade_lines = irq_acknowledge_in_n ? ~lvl : lvl;
  always_comb begin
    if (!chip_select_n && !read_n)
      data_in = address_select ? mask_set :
        (show_service ? in_service : request_inputs);
    else if (!irq_acknowledge_in_n)
      data_in = acks == 2'h0 ? 8'hcd :
        (acks == 2'h1 ? {3'h0, lvl, 2'h0} : vec_hi);
    else
      data_in = junk;
  end
  always @(posedge clk) begin
    junk <= ~junk;
    wr_q <= write_n;
    ack_q <= irq_acknowledge_in_n;
    idle <= !irq_acknowledge_in_n ? 5'h00 :
      (idle == 5'h1f ? idle : idle + 5'h01);
    if (!irq_acknowledge_in_n && ack_q) begin
      acks <= (idle == 5'h1f) ? 2'h0 : acks + 2'h1;
      if (idle == 5'h1f) in_service <= 8'h01 << lvl;
    end
    if (!chip_select_n && !write_n && wr_q) begin
      if (address_select && init_left != 2'h0) begin
        if (init_left == 2'h2) vec_hi <= data_out;
        init_left <= init_left - 2'h1;
      end else if (address_select) mask_set <= data_out;
      else if (data_out[4]) begin
        init_left <= 2'h2;
        mask_set <= 8'h00;
      end else if (data_out[3]) show_service <= data_out[0];
      else in_service <= 8'h00;
    end
  end
endmodule : pic_device_model

// [sim/pic_host_tb_top.sv]
`timescale 1ns/100ps
module pic_host_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0, cmd_write = 1'b0, cmd_addr_sel = 1'b0;
  logic [7:0] cmd_data = 8'h00, raise_req = 8'h00;
  logic ack_enable = 1'b0, ack_call_mode = 1'b1, buffered_mode = 1'b0;
  logic cmd_ready, rsp_valid, vec_valid, chip_select_n, write_n, read_n;
  logic address_select, data_oe_n, int_in, irq_acknowledge_in_n;
  logic slave_prog_out, slave_prog_oe_n;
  logic [7:0] rsp_data, request_inputs, data_out, data_in;
  logic [23:0] vec_data;
  logic [2:0] vec_cascade, cascade_lines;
  int fails = 0;
  int checks_done = 0;
  // Rows: write, select, byte, expected read byte
  logic [17:0] rows [0:7] = '{18'h21300, 18'h34000, 18'h30000,
    18'h3f000, 18'h100f0, 18'h20b00, 18'h00000, 18'h20a00};
  always #2 clk = ~clk;
  pic_host dut (.*);
  pic_device_model dev (.*);
  task chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte
  task chk_vec(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_vec
  task final_report;
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report
  task do_cmd(input logic w, input logic a, input logic [7:0] d);
    int n;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr_sel = a;
    cmd_data = d;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk_byte({7'h0, cmd_ready}, 8'h01);
    @(negedge clk);
    cmd_valid = 1'b0;
    n = 0;
    while (!w && rsp_valid !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    if (!w) chk_byte({7'h0, rsp_valid}, 8'h01);
  endtask : do_cmd
  task pulse_req(input logic [7:0] r);
    int n;
    raise_req = r;
    @(negedge clk);
    raise_req = 8'h00;
    n = 0;
    while (vec_valid !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk_byte({7'h0, vec_valid}, 8'h01);
  endtask : pulse_req
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    final_report();
  end
  initial begin
    repeat (2) @(negedge clk);
    chk_byte({5'h0, chip_select_n, data_oe_n, irq_acknowledge_in_n}, 8'h07);
    chk_byte({7'h0, slave_prog_out}, 8'h01);
    rst_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      do_cmd(rows[i][17], rows[i][16], rows[i][15:8]);
      if (!rows[i][17]) chk_byte(rsp_data, rows[i][7:0]);
    end
    ack_enable = 1'b1;
    raise_req = 8'h20;
    @(negedge clk);
    raise_req = 8'h00;
    do_cmd(1'b0, 1'b0, 8'h00);
    chk_byte(rsp_data, 8'h20);
    do_cmd(1'b1, 1'b1, 8'h00);
    chk_byte({7'h0, address_select}, 8'h01);
    chk_byte({6'h0, chip_select_n, data_oe_n}, 8'h00);
    pulse_req(8'h00);
    chk_vec(vec_data, 24'h4014cd);
    chk_byte({5'h0, vec_cascade}, 8'h05);
    chk_byte(request_inputs, 8'h00);
    do_cmd(1'b1, 1'b0, 8'h0b);
    do_cmd(1'b0, 1'b0, 8'h00);
    chk_byte(rsp_data, 8'h20);
    do_cmd(1'b1, 1'b0, 8'h20);
    chk_byte(data_out, 8'h20);
    do_cmd(1'b0, 1'b0, 8'h00);
    chk_byte(rsp_data, 8'h00);
    ack_call_mode = 1'b0;
    pulse_req(8'h80);
    chk_byte(vec_data[15:8], 8'h1c);
    chk_byte({5'h0, vec_cascade}, 8'h07);
    buffered_mode = 1'b1;
    @(negedge clk);
    chk_byte({7'h0, slave_prog_oe_n}, 8'h01);
    final_report();
  end
endmodule : pic_host_tb_top
